// ===== logic/sleep_wake_params.svh
// Purpose: Offsets, field positions, reset values and timing for the sleep/wake block
// Assumes: Register index times four is the Wishbone byte address
// Notes: Definitions only
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH
`define IDX_PORT_CFG 6'h00
`define IDX_WAKE1 6'h0b
`define IDX_WAKE2 6'h0d
`define IDX_STATUS 6'h0e
`define PCFG_COMP_BIT 0
`define PCFG_PP_BIT 2
`define W_DIV_BIT 0
`define W_SRC_LO 2
`define W_SRC_HI 4
`define W_DELAY_BIT 5
`define W_POL_BIT 6
`define W_WARM_BIT 7
`define RST_DELAY 1'b1
`define RST_POL 1'b0
`define RST_SRC 3'h0
`define RST_DIV 1'b0
`define RST_COMP 1'b0
`define RST_PP 1'b0
`define POR_TIME_US 5000
`define RC_OSC_KHZ 1000
`define RESTART_VECTOR 16'h000c
`endif

// ===== logic/sleep_wake_pkg.sv
// Purpose: Types shared by the sleep/wake block and its bench
// Assumes: Widths fixed
// Notes: Constants live in sleep_wake_params.svh
package sleep_wake_pkg;
  typedef enum logic [2:0] {
    ST_POR_WAIT = 3'b000,
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_STOP = 3'b011,
    ST_POWER_FAIL = 3'b100,
    ST_EXT_RESET = 3'b101
  } mode_type;
  typedef struct packed {
    logic [7:0] p2;
    logic [2:0] p3;
    logic p00;
    logic p07;
    logic supply_ok;
    logic ext_reset_n;
    logic rc_osc;
  } pins_type;
  typedef struct packed {
    logic [7:0] p0_data;
    logic [7:0] p0_dir;
    logic [7:0] p2_dir;
    logic p34_data;
    logic p37_data;
    logic [1:0] comp;
  } core_port_type;
  typedef struct packed {
    logic [7:0] p0_out;
    logic [7:0] p0_oe;
    logic p34_out;
    logic p37_out;
  } port_drive_type;
  typedef struct packed {
    logic cpu_clock_en;
    logic timer_clock_en;
    logic crystal_en;
    logic exec_en;
    logic restart;
    logic halt_resume;
    logic div16;
    logic [15:0] restart_vector;
  } power_out_type;
  typedef struct packed {
    pins_type s1;
    pins_type s2;
    pins_type s3;
    pins_type filt;
    logic rc_prev;
    mode_type mode;
    logic [19:0] por_count;
    logic warm;
    logic div16;
    logic [2:0] src1;
    logic delay_en;
    logic pol1;
    logic [2:0] src2;
    logic pol2;
    logic comp_route;
    logic push_pull;
    logic ack;
    logic [31:0] dat;
    port_drive_type drive;
    power_out_type pwr;
  } state_type;
endpackage : sleep_wake_pkg

// ===== logic/sleep_wake_reset_control.sv
// Purpose: Power-on delay, halt/stop sleep control, stop wake sources, port config
// Assumes: Classic Wishbone slave, 8-bit registers in lane 0, one clock
// Notes: Pins pass a three-flop synchroniser with agreement filter
//   Leaving supply standby is a full power-on: wake setup and port config return to defaults
//   An external reset holds a running power-on delay rather than cutting it short
//   Wake sources are compared as levels, so a transition source must stay at its new level
// Summary of operation
// R1 - Power-on delay starts on supply good, watchdog time-out, or delayed stop wake.
// R2 - Execution is held for the nominal five millisecond delay counted on RC ticks.
// R3 - Halt gates the CPU clock; crystal, timers and interrupts keep running.
// R4 - Halt ends only on a taken interrupt; execution resumes after halt. The code also ends halt on watchdog, external reset or supply fail.
// R5 - Stop stops clock and crystal; only resets or wake end it, restart at 000c.
// R6 - Software puts a no-op before the stop or halt instruction.
// R7 - Port config bit 0 routes comparator outputs to port 3 bits 4 and 7.
// R8 - Port config bit 2 picks push-pull or open-drain for port 0.
// R9 - Primary wake register is write-only except read-only bit 7.
// R10 - Bit 7 sets on stop wake, clears after any other reset.
// R11 - Bit 0 enables divide-by-16 prescale; forced to 0 on stop wake.
// R12 - Bits 4..2 pick the primary wake source from port 3 and port 2 pins.
// R13 - Pins set as outputs are left out of every wake combination.
// R14 - Bit 5 defaults to 1 for delayed wake; 0 bypasses the delay.
// R15 - With fast wake the source stays active at least five crystal periods.
// R16 - Bit 6 sets wake level polarity; low after power-on.
// R17 - Stop ends when either the primary or secondary source becomes active.
// R18 - Secondary bits 4..2 pick NOR or NAND combinations of port pins.
// R19 - Secondary bits 4..2 and 6 are write-only; bit 6 is wake polarity.
// R20 - Software writes zero to secondary reserved bits 7, 5, 1 and 0.
// R21 - Execution stays suspended while the delay runs, released at end or bypass.
`timescale 1ns/1ps
`include "sleep_wake_params.svh"
module sleep_wake_reset_control #(
  parameter logic [19:0] por_rc_ticks = 20'(`POR_TIME_US * `RC_OSC_KHZ / 1000)
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire sleep_wake_pkg::pins_type pins,
  input wire sleep_wake_pkg::core_port_type core,
  input wire logic watchdog_timeout,
  input wire logic irq_wake,
  input wire logic halt_req,
  input wire logic stop_req,
  output sleep_wake_pkg::port_drive_type drive,
  output sleep_wake_pkg::power_out_type pwr
);
  sleep_wake_pkg::state_type st_ff;
  sleep_wake_pkg::state_type nxt_st;

  always_comb begin
    logic req;
    logic wr;
    logic [5:0] idx;
    logic tick;
    logic [7:0] p2z;
    logic [7:0] p2f;
    logic p00z;
    logic p07z;
    logic p00f;
    logic p07f;
    logic f1;
    logic v1;
    logic f2;
    logic v2;
    logic wake;
    logic [7:0] rd;
    req = 1'b0;
    wr = 1'b0;
    idx = 6'h00;
    tick = 1'b0;
    p2z = 8'h00;
    p2f = 8'h00;
    p00z = 1'b0;
    p07z = 1'b0;
    p00f = 1'b0;
    p07f = 1'b0;
    f1 = 1'b0;
    v1 = 1'b0;
    f2 = 1'b0;
    v2 = 1'b0;
    wake = 1'b0;
    rd = 8'h00;
    nxt_st = st_ff;

    // Synchroniser; filtered value moves only when stages two and three agree
    nxt_st.s1 = pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.filt = (st_ff.s2 & st_ff.s3) | (st_ff.filt & (st_ff.s2 ^ st_ff.s3));
    nxt_st.rc_prev = st_ff.filt.rc_osc;
    tick = st_ff.filt.rc_osc & ~st_ff.rc_prev;

    // Bus slave: ack one cycle after the strobe, write on the acked edge
    req = wb_cyc_i & wb_stb_i;
    idx = wb_adr_i[7:2];
    wr = req & wb_we_i & st_ff.ack & wb_sel_i[0] & (wb_adr_i[1:0] == 2'h0);
    nxt_st.ack = req & ~st_ff.ack;
    if (req && !st_ff.ack) begin
      rd = 8'h00;
      if (wb_adr_i[1:0] == 2'h0 && idx == `IDX_WAKE1) begin
        rd[`W_WARM_BIT] = st_ff.warm; // [R9]
      end else if (wb_adr_i[1:0] == 2'h0 && idx == `IDX_STATUS) begin
        rd = {2'h0, st_ff.div16, st_ff.warm, st_ff.pwr.exec_en, st_ff.mode};
      end
      nxt_st.dat = {24'h000000, rd};
    end
    if (wr) begin
      unique case (idx)
        `IDX_PORT_CFG: begin
          nxt_st.comp_route = wb_dat_i[`PCFG_COMP_BIT]; // [R7]
          nxt_st.push_pull = wb_dat_i[`PCFG_PP_BIT]; // [R8]
        end
        `IDX_WAKE1: begin
          nxt_st.div16 = wb_dat_i[`W_DIV_BIT]; // [R11]
          nxt_st.src1 = wb_dat_i[`W_SRC_HI:`W_SRC_LO]; // [R12]
          nxt_st.delay_en = wb_dat_i[`W_DELAY_BIT]; // [R14]
          nxt_st.pol1 = wb_dat_i[`W_POL_BIT]; // [R16]
        end
        `IDX_WAKE2: begin
          nxt_st.src2 = wb_dat_i[`W_SRC_HI:`W_SRC_LO]; // [R19]
          nxt_st.pol2 = wb_dat_i[`W_POL_BIT]; // [R19]
        end
        default: begin
        end
      endcase
    end

    // Output pins read as neutral: 0 for NOR terms, 1 for NAND terms
    p2z = st_ff.filt.p2 & ~core.p2_dir; // [R13]
    p2f = st_ff.filt.p2 | core.p2_dir; // [R13]
    p00z = st_ff.filt.p00 & ~core.p0_dir[0];
    p07z = st_ff.filt.p07 & ~core.p0_dir[7];
    p00f = st_ff.filt.p00 | core.p0_dir[0];
    p07f = st_ff.filt.p07 | core.p0_dir[7];

    unique case (st_ff.src1) // [R12]
      3'h2: begin
        f1 = st_ff.filt.p3[0];
        v1 = 1'b1;
      end
      3'h3: begin
        f1 = st_ff.filt.p3[1];
        v1 = 1'b1;
      end
      3'h4: begin
        f1 = st_ff.filt.p3[2];
        v1 = 1'b1;
      end
      3'h5: begin
        f1 = st_ff.filt.p2[7];
        v1 = ~core.p2_dir[7]; // [R13]
      end
      3'h6: begin
        f1 = ~|p2z[3:0];
        v1 = 1'b1;
      end
      3'h7: begin
        f1 = ~|p2z;
        v1 = 1'b1;
      end
      default: begin
        f1 = 1'b0;
        v1 = 1'b0;
      end
    endcase
    unique case (st_ff.src2) // [R18]
      3'h1: begin
        f2 = ~&p2f[3:0];
        v2 = 1'b1;
      end
      3'h2: begin
        f2 = ~&p2f;
        v2 = 1'b1;
      end
      3'h3: begin
        f2 = ~|st_ff.filt.p3;
        v2 = 1'b1;
      end
      3'h4: begin
        f2 = ~&st_ff.filt.p3;
        v2 = 1'b1;
      end
      3'h5: begin
        f2 = ~|{st_ff.filt.p3, p00z, p07z};
        v2 = 1'b1;
      end
      3'h6: begin
        f2 = ~&{st_ff.filt.p3, p00f, p07f};
        v2 = 1'b1;
      end
      3'h7: begin
        f2 = ~&{st_ff.filt.p3, p2f[2:0]};
        v2 = 1'b1;
      end
      default: begin
        f2 = 1'b0;
        v2 = 1'b0;
      end
    endcase
    // Level compare at the polarity gate; fast wake relies on the source being held
    wake = (v1 & ~(f1 ^ st_ff.pol1)) | (v2 & ~(f2 ^ st_ff.pol2)); // [R16] [R17] [R15]

    nxt_st.pwr.restart = 1'b0;
    nxt_st.pwr.halt_resume = 1'b0;
    if (!st_ff.filt.supply_ok) begin
      nxt_st.mode = sleep_wake_pkg::ST_POWER_FAIL;
      nxt_st.warm = 1'b0; // [R10]
      // Supply recovery is a power-on, so the write-only setup takes its defaults again
      nxt_st.delay_en = `RST_DELAY; // [R14]
      nxt_st.pol1 = `RST_POL; // [R16]
      nxt_st.pol2 = `RST_POL; // [R19]
      nxt_st.src1 = `RST_SRC;
      nxt_st.src2 = `RST_SRC;
      nxt_st.div16 = `RST_DIV;
      nxt_st.comp_route = `RST_COMP;
      nxt_st.push_pull = `RST_PP;
    end else if (st_ff.mode == sleep_wake_pkg::ST_POWER_FAIL) begin
      nxt_st.mode = sleep_wake_pkg::ST_POR_WAIT; // [R1]
      nxt_st.por_count = 20'h00000;
    end else if (watchdog_timeout) begin
      nxt_st.mode = sleep_wake_pkg::ST_POR_WAIT; // [R1]
      nxt_st.por_count = 20'h00000;
      nxt_st.warm = 1'b0; // [R10]
    end else if (!st_ff.filt.ext_reset_n) begin
      nxt_st.warm = 1'b0; // [R10]
      // Releasing the pin must not skip a power-on delay that is still running
      if (st_ff.mode != sleep_wake_pkg::ST_POR_WAIT) begin
        nxt_st.mode = sleep_wake_pkg::ST_EXT_RESET; // [R5] [R21]
      end
    end else begin
      unique case (st_ff.mode)
        sleep_wake_pkg::ST_POR_WAIT: begin
          if (tick) begin
            nxt_st.por_count = st_ff.por_count + 20'h00001; // [R2]
          end
          if (st_ff.por_count >= por_rc_ticks) begin
            nxt_st.mode = sleep_wake_pkg::ST_RUN; // [R21]
            nxt_st.pwr.restart = 1'b1;
          end
        end
        sleep_wake_pkg::ST_RUN: begin
          if (stop_req) begin
            nxt_st.mode = sleep_wake_pkg::ST_STOP; // [R5]
          end else if (halt_req) begin
            nxt_st.mode = sleep_wake_pkg::ST_HALT; // [R3]
          end
        end
        sleep_wake_pkg::ST_HALT: begin
          if (irq_wake) begin
            nxt_st.mode = sleep_wake_pkg::ST_RUN; // [R4]
            nxt_st.pwr.halt_resume = 1'b1;
          end
        end
        sleep_wake_pkg::ST_STOP: begin
          if (wake) begin
            nxt_st.warm = 1'b1; // [R10]
            nxt_st.div16 = 1'b0; // [R11]
            if (st_ff.delay_en) begin
              nxt_st.mode = sleep_wake_pkg::ST_POR_WAIT; // [R1] [R14]
              nxt_st.por_count = 20'h00000;
            end else begin
              nxt_st.mode = sleep_wake_pkg::ST_RUN; // [R14] [R21]
              nxt_st.pwr.restart = 1'b1;
            end
          end
        end
        sleep_wake_pkg::ST_EXT_RESET: begin
          nxt_st.mode = sleep_wake_pkg::ST_RUN; // [R5]
          nxt_st.pwr.restart = 1'b1;
        end
        default: begin
          nxt_st.mode = sleep_wake_pkg::ST_POR_WAIT;
          nxt_st.por_count = 20'h00000;
        end
      endcase
    end

    nxt_st.pwr.cpu_clock_en = nxt_st.mode == sleep_wake_pkg::ST_RUN; // [R3]
    nxt_st.pwr.timer_clock_en = nxt_st.mode == sleep_wake_pkg::ST_RUN ||
                                nxt_st.mode == sleep_wake_pkg::ST_HALT; // [R3]
    nxt_st.pwr.crystal_en = nxt_st.mode != sleep_wake_pkg::ST_STOP &&
                            nxt_st.mode != sleep_wake_pkg::ST_POWER_FAIL; // [R5]
    nxt_st.pwr.exec_en = nxt_st.mode == sleep_wake_pkg::ST_RUN; // [R21] [R2]
    nxt_st.pwr.div16 = nxt_st.div16; // [R11]
    nxt_st.pwr.restart_vector = `RESTART_VECTOR; // [R5]

    // Comparators take the port 3 pins only while routed
    nxt_st.drive.p34_out = st_ff.comp_route ? core.comp[0] : core.p34_data; // [R7]
    nxt_st.drive.p37_out = st_ff.comp_route ? core.comp[1] : core.p37_data; // [R7]
    nxt_st.drive.p0_out = core.p0_data;
    // Open drain drives only the low level
    nxt_st.drive.p0_oe = core.p0_dir & (st_ff.push_pull ? 8'hff : ~core.p0_data); // [R8]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.mode <= sleep_wake_pkg::ST_POR_WAIT; // [R1]
      st_ff.delay_en <= `RST_DELAY; // [R14]
      st_ff.pol1 <= `RST_POL; // [R16]
      st_ff.pol2 <= `RST_POL; // [R19]
      st_ff.src1 <= `RST_SRC;
      st_ff.src2 <= `RST_SRC;
      st_ff.div16 <= `RST_DIV;
      st_ff.comp_route <= `RST_COMP;
      st_ff.push_pull <= `RST_PP;
      st_ff.pwr.crystal_en <= 1'b1;
      st_ff.pwr.restart_vector <= `RESTART_VECTOR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.dat;
  assign drive = st_ff.drive;
  assign pwr = st_ff.pwr;
endmodule : sleep_wake_reset_control

// ===== verification/sleep_wake_reset_control_assertions.sv
// Purpose: Port-level assertions for the sleep/wake block
// Assumes: One clock, async active-high reset
// Notes: Bound into every instance of the block
`timescale 1ns/1ps
module sleep_wake_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire sleep_wake_pkg::power_out_type pwr
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper lanes not zero");
  vector_fixed_a: assert property (pwr.restart_vector == 16'h000c)
    else $error("restart vector wrong");
  stop_clock_a: assert property ($fell(pwr.crystal_en) |-> !pwr.cpu_clock_en)
    else $error("crystal stopped with cpu clock running");
  resume_pulse_a: assert property (pwr.halt_resume |-> pwr.crystal_en ##1 !pwr.halt_resume)
    else $error("halt resume pulse malformed");
  restart_exec_a: assert property (pwr.restart |-> pwr.exec_en)
    else $error("restart without execution enabled");
  restart_once_a: assert property (pwr.restart |=> !pwr.restart)
    else $error("restart pulse longer than one cycle");
endmodule : sleep_wake_checker
bind sleep_wake_reset_control sleep_wake_checker u_chk (.clock, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_dat_o, .wb_ack_o, .pwr);

// ===== verification/sleep_wake_reset_control_tb.sv
// Purpose: Directed bench for the sleep/wake block
// Assumes: Short power-on delay parameter; RC tick every 10 clocks
// Notes: Pins go through a synchroniser, so waits are bounded loops
`timescale 1ns/1ps
module sleep_wake_reset_control_tb;
  logic clock, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic watchdog_timeout, irq_wake, halt_req, stop_req;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [3:0] wb_sel_i, rc_cnt;
  int err_total, checked, n;
  sleep_wake_pkg::pins_type pins;
  sleep_wake_pkg::core_port_type core;
  sleep_wake_pkg::port_drive_type drive;
  sleep_wake_pkg::power_out_type pwr;
  sleep_wake_reset_control #(.por_rc_ticks(20'h00004)) u_dut (.clock, .rst, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pins,
    .core, .watchdog_timeout, .irq_wake, .halt_req, .stop_req, .drive, .pwr);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Slow RC oscillator stand-in; real ratio would make the delay far too long
  always @(posedge clock) begin
    rc_cnt <= (rc_cnt == 4'h4) ? 4'h0 : rc_cnt + 4'h1;
    if (rc_cnt == 4'h4) pins.rc_osc <= ~pins.rc_osc;
  end
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, d};
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] adr, input logic [7:0] exp, input string name);
    wb(1'b0, adr, 8'h00);
    check(name, {24'h000000, exp}, q);
  endtask : rd
  // Counts cycles to a one-cycle pulse: restart when sel is 0, halt resume otherwise
  task automatic wait_bit(input int sel, output int cyc);
    cyc = 0;
    while ((sel ? pwr.halt_resume : pwr.restart) !== 1'b1 && cyc < 3000) begin
      @(posedge clock);
      cyc++;
    end
    check("pulse_seen", 32'h1, {31'h0, cyc < 3000});
  endtask : wait_bit
  // Core side: one clean request per sleep instruction, its flushing no-op already done
  task automatic pulse_req(input int sel);
    @(posedge clock);
    if (sel == 0) halt_req <= 1'b1;
    else if (sel == 1) stop_req <= 1'b1;
    else watchdog_timeout <= 1'b1;
    @(posedge clock);
    {halt_req, stop_req, watchdog_timeout} <= 3'b000;
    repeat (8) @(posedge clock);
  endtask : pulse_req
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    print_verdict();
  end
  initial begin
    {rst, wb_we_i, wb_cyc_i, wb_stb_i, watchdog_timeout, irq_wake, halt_req, stop_req} = 8'h80;
    {wb_adr_i, wb_dat_i, rc_cnt, err_total, checked} = '0;
    wb_sel_i = 4'h1;
    pins = '0;
    pins.supply_ok = 1'b1;
    pins.ext_reset_n = 1'b1;
    core = '0;
    core.comp = 2'b10;
    core.p34_data = 1'b1;
    core.p0_dir = 8'hff;
    core.p0_data = 8'h0f;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    wait_bit(0, n);
    check("por_hold", 32'h1, {31'h0, n > 30});
    check("exec_run", 32'h1, {31'h0, pwr.exec_en});
    check("vector", 32'h000c, {16'h0, pwr.restart_vector});
    rd(8'h2c, 8'h00, "cold_flag");
    rd(8'h00, 8'h00, "pcfg_read");
    rd(8'h3c, 8'h00, "unmapped");
    wb(1'b1, 8'h00, 8'h05);
    repeat (3) @(posedge clock);
    check("comp_route", 32'h2, {30'h0, drive.p37_out, drive.p34_out});
    check("push_pull", 32'hff, {24'h0, drive.p0_oe});
    check("p0_data", 32'h0f, {24'h0, drive.p0_out});
    wb(1'b1, 8'h00, 8'h00);
    repeat (3) @(posedge clock);
    check("io_route", 32'h1, {30'h0, drive.p37_out, drive.p34_out});
    check("open_drain", 32'hf0, {24'h0, drive.p0_oe});
    pulse_req(0);
    check("halt_clk", 32'h2, {30'h0, pwr.crystal_en, pwr.cpu_clock_en});
    check("halt_timer", 32'h1, {31'h0, pwr.timer_clock_en});
    rd(8'h38, 8'h02, "status_halt");
    irq_wake <= 1'b1;
    wait_bit(1, n);
    irq_wake <= 1'b0;
    repeat (2) @(posedge clock);
    check("halt_exit", 32'h1, {31'h0, pwr.cpu_clock_en});
    // Output pin P20 is high but must be ignored, so the NOR of P21..P23 wakes
    core.p2_dir <= 8'h01;
    pins.p2 <= 8'hff;
    wb(1'b1, 8'h2c, 8'h59);
    // The write lands on the edge the task returns on; look one edge later
    @(posedge clock);
    check("div16_on", 32'h1, {31'h0, pwr.div16});
    pulse_req(1);
    check("stop_xtal", 32'h0, {31'h0, pwr.crystal_en});
    pins.p2 <= 8'h01;
    wait_bit(0, n);
    check("fast_wake", 32'h1, {31'h0, n < 20});
    check("div16_off", 32'h0, {31'h0, pwr.div16});
    rd(8'h2c, 8'h80, "warm_flag");
    wb(1'b1, 8'h2c, 8'h20);
    wb(1'b1, 8'h34, 8'h4c);
    rd(8'h34, 8'h00, "second_read");
    pins.p3 <= 3'b111;
    // Let the synchroniser settle, or stale low pins wake the block at once
    repeat (4) @(posedge clock);
    pulse_req(1);
    pins.p3 <= 3'b000;
    wait_bit(0, n);
    check("slow_wake", 32'h1, {31'h0, n > 30});
    rd(8'h2c, 8'h80, "warm_again");
    pulse_req(2);
    wait_bit(0, n);
    // The wait began nine edges after the time-out, so add them back
    check("wdog_hold", 32'h1, {31'h0, n + 9 > 30});
    rd(8'h2c, 8'h00, "cold_again");
    pins.p3 <= 3'b111;
    repeat (4) @(posedge clock);
    pulse_req(1);
    pins.ext_reset_n <= 1'b0;
    repeat (6) @(posedge clock);
    rd(8'h38, 8'h05, "ext_status");
    pins.ext_reset_n <= 1'b1;
    wait_bit(0, n);
    check("ext_fast", 32'h1, {31'h0, n < 20});
    wb(1'b1, 8'h2c, 8'h61);
    @(posedge clock);
    check("div16_set", 32'h1, {31'h0, pwr.div16});
    pins.supply_ok <= 1'b0;
    repeat (8) @(posedge clock);
    check("fail_xtal", 32'h0, {31'h0, pwr.crystal_en});
    pins.supply_ok <= 1'b1;
    wait_bit(0, n);
    check("supply_hold", 32'h1, {31'h0, n > 30});
    rd(8'h38, 8'h09, "power_on_status");
    print_verdict();
  end
endmodule : sleep_wake_reset_control_tb
